// File: hdl/guard_pkg.sv
package guard_pkg;
   localparam int SECTORS   = 16;
   localparam int SECTOR_W  = 4;
   localparam int GUARD_W   = 8;
   localparam int PWD_W     = 32;
   localparam int PWD_COUNT = 3;
   localparam int SEL_W     = 2;

   localparam int LOCK_BIT  = 0;
   localparam int PROT_LSB  = 1;
   localparam int PROT_MSB  = 2;
   localparam int SEL_LSB   = 3;
   localparam int SEL_MSB   = 4;
   localparam int FIELD_MSB = 4;

   localparam logic [7:0]  GUARD_RESET = 8'h00;
   localparam logic [31:0] PWD_RESET   = 32'h0000_0000;
   localparam logic [2:0]  ZERO_TOP    = 3'h0;

   localparam logic [11:0] SECTOR_GUARD_WORD_0 = 12'h000;
   localparam logic [11:0] SECTOR_GUARD_WORD_1 = 12'h004;
   localparam logic [11:0] SECTOR_GUARD_WORD_2 = 12'h008;
   localparam logic [11:0] SECTOR_GUARD_WORD_3 = 12'h00C;
   localparam logic [8:0]  PASSWORD_ONE        = 9'h001;
   localparam logic [8:0]  PASSWORD_TWO        = 9'h002;
   localparam logic [8:0]  PASSWORD_THREE      = 9'h003;

   localparam logic [1:0] PROT_WRITE_PWD = 2'h0;
   localparam logic [1:0] PROT_OPEN      = 2'h1;
   localparam logic [1:0] PROT_RW_PWD    = 2'h2;
   localparam logic [1:0] PROT_READ_PWD  = 2'h3;
   localparam logic [1:0] SEL_NONE       = 2'h0;

   localparam logic [2:0] CMD_READ      = 3'h0;
   localparam logic [2:0] CMD_WRITE     = 3'h1;
   localparam logic [2:0] CMD_WRITE_PWD = 3'h2;
   localparam logic [2:0] CMD_LOCK      = 3'h3;
   localparam logic [2:0] CMD_PRESENT   = 3'h4;

   localparam logic [1:0] RESP_OK     = 2'h0;
   localparam logic [1:0] RESP_DENIED = 2'h1;
   localparam logic [1:0] RESP_LOCKED = 2'h2;
   localparam logic [1:0] RESP_BAD    = 2'h3;

   localparam int CLK_PERIOD_NS    = 100;
   localparam int RF_WRITE_TIME_NS = 5750000;
   localparam int RF_WRITE_CYCLES  =
      (RF_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: hdl/sector_rights_eval.sv
`timescale 1ns/100ps
module sector_rights_eval (
   input  wire logic [7:0] guard_byte_i,
   input  wire logic       granted_i,
   output logic            read_ok_o,
   output logic            write_ok_o
);
   logic [1:0] prot;

   assign prot = guard_byte_i[guard_pkg::PROT_MSB:guard_pkg::PROT_LSB];

   always_comb begin
      read_ok_o  = 1'b1;
      write_ok_o = 1'b1;
      if (guard_byte_i[guard_pkg::LOCK_BIT]) begin
         unique case (prot)
            guard_pkg::PROT_WRITE_PWD: begin
               write_ok_o = granted_i;
            end
            guard_pkg::PROT_OPEN: begin
               write_ok_o = 1'b1;
            end
            guard_pkg::PROT_RW_PWD: begin
               read_ok_o  = granted_i;
               write_ok_o = granted_i;
            end
            guard_pkg::PROT_READ_PWD: begin
               read_ok_o  = granted_i;
               write_ok_o = 1'b0;
            end
         endcase
      end
   end
endmodule

// File: hdl/rf_sector_password_guard.sv
`timescale 1ns/100ps
module rf_sector_password_guard #(
   parameter int WRITE_CYCLES = guard_pkg::RF_WRITE_CYCLES
) (
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   input  wire logic        rf_req_i,
   output logic             rf_ready_o,
   input  wire logic [2:0]  rf_cmd_i,
   input  wire logic [3:0]  rf_sector_i,
   input  wire logic        rf_opt_i,
   input  wire logic [1:0]  rf_pwd_sel_i,
   input  wire logic [31:0] rf_data_i,
   output logic             rf_done_o,
   output logic [1:0]       rf_status_o,
   output logic [7:0]       rf_guard_byte_o,
   output logic             rf_guard_valid_o,
   output logic [1:0]       rf_presented_o,
   input  wire logic        i2c_req_i,
   input  wire logic        i2c_we_i,
   input  wire logic        high_bank_select_i,
   input  wire logic [3:0]  i2c_addr_i,
   input  wire logic [7:0]  i2c_wdata_i,
   input  wire logic        i2c_pwd_ok_i,
   output logic             i2c_ack_o,
   output logic             i2c_denied_o,
   output logic [7:0]       i2c_rdata_o
);
   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES);

   typedef enum logic {IDLE, WRITE_WAIT} guard_state_t;

   logic [7:0]       guard_reg   [guard_pkg::SECTORS];
   logic [7:0]       guard_next  [guard_pkg::SECTORS];
   logic [31:0]      pwd_reg     [guard_pkg::PWD_COUNT];
   logic [31:0]      pwd_next    [guard_pkg::PWD_COUNT];
   logic [15:0]      void_reg;
   logic [15:0]      void_next;
   logic [1:0]       presented_reg;
   logic [1:0]       presented_next;
   guard_state_t     state_reg;
   guard_state_t     state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [1:0]       pend_sel_reg;
   logic [1:0]       pend_sel_next;
   logic [31:0]      pend_val_reg;
   logic [31:0]      pend_val_next;

   logic             done_reg;
   logic             done_next;
   logic [1:0]       status_reg;
   logic [1:0]       status_next;
   logic [7:0]       gbyte_reg;
   logic [7:0]       gbyte_next;
   logic             gvalid_reg;
   logic             gvalid_next;
   logic             ack_reg;
   logic             ack_next;
   logic             denied_reg;
   logic             denied_next;
   logic [7:0]       rdata_reg;
   logic [7:0]       rdata_next;

   logic             i2c_hit;
   logic             i2c_wr_ok;
   logic             rf_fire;
   logic [7:0]       sel_guard;
   logic [1:0]       sel_pwd;
   logic             granted;
   logic             read_ok;
   logic             write_ok;
   logic             pwd_match;
   logic             write_end;
   logic             pwd_hit     [guard_pkg::PWD_COUNT];
   logic             pwd_load    [guard_pkg::PWD_COUNT];

   // guard bytes live on the high bank only
   assign i2c_hit   = i2c_req_i & high_bank_select_i;
   assign i2c_wr_ok = i2c_hit & i2c_we_i & i2c_pwd_ok_i;

   // I2C wins the shared store, so RF waits a cycle rather than race it
   assign rf_ready_o = (state_reg == IDLE) & ~i2c_req_i;
   assign rf_fire    = rf_req_i & rf_ready_o;

   assign sel_guard = guard_reg[rf_sector_i];
   assign sel_pwd   = sel_guard[guard_pkg::SEL_MSB:guard_pkg::SEL_LSB];

   // right exists only if linked password was presented and not voided
   assign granted = (sel_pwd != guard_pkg::SEL_NONE)
                  & (sel_pwd == presented_reg)
                  & ~void_reg[rf_sector_i];

   assign write_end = (state_reg == WRITE_WAIT) & (cnt_reg == CNT_LAST);

   // one comparator per stored password; selector 0 picks none and so never matches
   for (genvar p = 0; p < guard_pkg::PWD_COUNT; p++) begin : g_pwd
      assign pwd_hit[p]  = (rf_data_i == pwd_reg[p]);
      assign pwd_load[p] = write_end & (pend_sel_reg == 2'(p + 1));
   end

   always_comb begin
      pwd_match = 1'b0;
      for (int p = 0; p < guard_pkg::PWD_COUNT; p++) begin
         if (rf_pwd_sel_i == 2'(p + 1)) begin
            pwd_match = pwd_hit[p];
         end
      end
   end

   sector_rights_eval rights_u (
      .guard_byte_i (sel_guard),
      .granted_i    (granted),
      .read_ok_o    (read_ok),
      .write_ok_o   (write_ok)
   );

   always_comb begin
      guard_next     = guard_reg;
      pwd_next       = pwd_reg;
      void_next      = void_reg;
      presented_next = presented_reg;
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      pend_sel_next  = pend_sel_reg;
      pend_val_next  = pend_val_reg;
      if (rf_fire) begin
         unique case (rf_cmd_i)
            guard_pkg::CMD_LOCK: begin
               // a locked byte is frozen for RF; only an I2C write may change it
               if (!sel_guard[guard_pkg::LOCK_BIT]) begin
                  guard_next[rf_sector_i] = {guard_pkg::ZERO_TOP,
                     rf_data_i[guard_pkg::FIELD_MSB:guard_pkg::PROT_LSB],
                     1'b1};
               end
            end
            guard_pkg::CMD_PRESENT: begin
               if (pwd_match) begin
                  presented_next = rf_pwd_sel_i;
                  // a fresh presentation restores rights an I2C write had voided
                  void_next      = '0;
               end else begin
                  presented_next = guard_pkg::SEL_NONE;
               end
            end
            guard_pkg::CMD_WRITE_PWD: begin
               if (rf_pwd_sel_i != guard_pkg::SEL_NONE
                   && rf_pwd_sel_i == presented_reg) begin
                  state_next    = WRITE_WAIT;
                  cnt_next      = CNT_ONE;
                  pend_sel_next = rf_pwd_sel_i;
                  pend_val_next = rf_data_i;
               end
            end
            default: begin
            end
         endcase
      end
      // the write slot holds off every RF command, so nothing races the commit
      if (state_reg == WRITE_WAIT) begin
         cnt_next = cnt_reg + CNT_ONE;
         if (write_end) begin
            // old value keeps guarding until the cell is really written
            for (int p = 0; p < guard_pkg::PWD_COUNT; p++) begin
               if (pwd_load[p]) begin
                  pwd_next[p] = pend_val_reg;
               end
            end
            state_next = IDLE;
            cnt_next   = '0;
         end
      end
      // top bits are stored as zero whatever the master sends
      if (i2c_wr_ok) begin
         guard_next[i2c_addr_i] = {guard_pkg::ZERO_TOP,
            i2c_wdata_i[guard_pkg::FIELD_MSB:0]};
         void_next[i2c_addr_i]  = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int s = 0; s < guard_pkg::SECTORS; s++) begin
            guard_reg[s] <= guard_pkg::GUARD_RESET;
         end
         for (int p = 0; p < guard_pkg::PWD_COUNT; p++) begin
            pwd_reg[p] <= guard_pkg::PWD_RESET;
         end
         void_reg      <= '0;
         presented_reg <= guard_pkg::SEL_NONE;
         state_reg     <= IDLE;
         cnt_reg       <= '0;
         pend_sel_reg  <= guard_pkg::SEL_NONE;
         pend_val_reg  <= guard_pkg::PWD_RESET;
      end else begin
         guard_reg     <= guard_next;
         pwd_reg       <= pwd_next;
         void_reg      <= void_next;
         presented_reg <= presented_next;
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         pend_sel_reg  <= pend_sel_next;
         pend_val_reg  <= pend_val_next;
      end
   end

   // answer registers: pulses last one cycle, status and bytes hold
   always_comb begin
      done_next   = 1'b0;
      status_next = status_reg;
      gbyte_next  = gbyte_reg;
      gvalid_next = 1'b0;
      ack_next    = 1'b0;
      denied_next = 1'b0;
      rdata_next  = rdata_reg;
      if (rf_fire) begin
         done_next   = 1'b1;
         status_next = guard_pkg::RESP_OK;
         unique case (rf_cmd_i)
            guard_pkg::CMD_READ: begin
               if (!read_ok) begin
                  status_next = guard_pkg::RESP_DENIED;
               end else if (rf_opt_i) begin
                  gbyte_next  = sel_guard;
                  gvalid_next = 1'b1;
               end
            end
            guard_pkg::CMD_WRITE: begin
               if (!write_ok) begin
                  status_next = guard_pkg::RESP_DENIED;
               end
            end
            guard_pkg::CMD_WRITE_PWD: begin
               if (rf_pwd_sel_i == guard_pkg::SEL_NONE) begin
                  status_next = guard_pkg::RESP_BAD;
               end else if (rf_pwd_sel_i != presented_reg) begin
                  status_next = guard_pkg::RESP_DENIED;
               end else begin
                  done_next = 1'b0;
               end
            end
            guard_pkg::CMD_LOCK: begin
               if (sel_guard[guard_pkg::LOCK_BIT]) begin
                  status_next = guard_pkg::RESP_LOCKED;
               end
            end
            guard_pkg::CMD_PRESENT: begin
               if (rf_pwd_sel_i == guard_pkg::SEL_NONE) begin
                  status_next = guard_pkg::RESP_BAD;
               end else if (!pwd_match) begin
                  status_next = guard_pkg::RESP_DENIED;
               end
            end
            default: begin
               status_next = guard_pkg::RESP_BAD;
            end
         endcase
      end
      if (write_end) begin
         done_next   = 1'b1;
         status_next = guard_pkg::RESP_OK;
      end
      if (i2c_hit) begin
         ack_next = 1'b1;
         if (i2c_we_i) begin
            denied_next = ~i2c_pwd_ok_i;
         end else begin
            rdata_next = guard_reg[i2c_addr_i];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         done_reg   <= 1'b0;
         status_reg <= guard_pkg::RESP_OK;
         gbyte_reg  <= guard_pkg::GUARD_RESET;
         gvalid_reg <= 1'b0;
         ack_reg    <= 1'b0;
         denied_reg <= 1'b0;
         rdata_reg  <= guard_pkg::GUARD_RESET;
      end else begin
         done_reg   <= done_next;
         status_reg <= status_next;
         gbyte_reg  <= gbyte_next;
         gvalid_reg <= gvalid_next;
         ack_reg    <= ack_next;
         denied_reg <= denied_next;
         rdata_reg  <= rdata_next;
      end
   end

   assign rf_done_o        = done_reg;
   assign rf_status_o      = status_reg;
   assign rf_guard_byte_o  = gbyte_reg;
   assign rf_guard_valid_o = gvalid_reg;
   assign rf_presented_o   = presented_reg;
   assign i2c_ack_o        = ack_reg;
   assign i2c_denied_o     = denied_reg;
   assign i2c_rdata_o      = rdata_reg;
endmodule

// File: dv/rf_sector_password_guard_props.sv
`timescale 1ns/100ps
module guard_props (
   input wire logic       mclk_i,
   input wire logic       resetn_i,
   input wire logic       rf_req_i,
   input wire logic       rf_ready_o,
   input wire logic [2:0] rf_cmd_i,
   input wire logic [1:0] rf_pwd_sel_i,
   input wire logic       rf_done_o,
   input wire logic [1:0] rf_status_o,
   input wire logic [7:0] rf_guard_byte_o,
   input wire logic       rf_guard_valid_o,
   input wire logic [1:0] rf_presented_o,
   input wire logic       i2c_req_i,
   input wire logic       i2c_we_i,
   input wire logic       high_bank_select_i,
   input wire logic       i2c_pwd_ok_i,
   input wire logic       i2c_ack_o,
   input wire logic       i2c_denied_o
);
   logic rf_take;
   logic i2c_take;
   assign rf_take  = rf_req_i && rf_ready_o;
   assign i2c_take = i2c_req_i && high_bank_select_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   property p_gv; rf_guard_valid_o |-> rf_done_o; endproperty
   a_gv: assert property (p_gv) else $error("guard valid without done");
   property p_rd; rf_take && rf_cmd_i == guard_pkg::CMD_READ |=> rf_done_o; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_top; rf_guard_valid_o |-> rf_guard_byte_o[7:5] == 3'h0; endproperty
   a_top: assert property (p_top) else $error("guard byte top bits set");
   property p_gok; rf_guard_valid_o |-> rf_status_o == guard_pkg::RESP_OK; endproperty
   a_gok: assert property (p_gok) else $error("guard byte on refused read");
   property p_bad;
      rf_take && rf_cmd_i == guard_pkg::CMD_PRESENT && rf_pwd_sel_i == 2'h0
      |=> rf_status_o == guard_pkg::RESP_BAD && rf_presented_o == 2'h0;
   endproperty
   a_bad: assert property (p_bad) else $error("bad present accepted");
   property p_deny;
      i2c_take && i2c_we_i && !i2c_pwd_ok_i |=> i2c_ack_o && i2c_denied_o;
   endproperty
   a_deny: assert property (p_deny) else $error("write without password not refused");
   property p_rdok; i2c_take && !i2c_we_i |-> ##1 i2c_ack_o && !i2c_denied_o; endproperty
   a_rdok: assert property (p_rdok) else $error("guard read refused");
   property p_noack; !i2c_take |=> !i2c_ack_o; endproperty
   a_noack: assert property (p_noack) else $error("ack without high bank");
endmodule
bind rf_sector_password_guard guard_props guard_props_i (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .rf_req_i(rf_req_i), .rf_ready_o(rf_ready_o),
   .rf_cmd_i(rf_cmd_i), .rf_pwd_sel_i(rf_pwd_sel_i), .rf_done_o(rf_done_o),
   .rf_status_o(rf_status_o), .rf_guard_byte_o(rf_guard_byte_o),
   .rf_guard_valid_o(rf_guard_valid_o), .rf_presented_o(rf_presented_o),
   .i2c_req_i(i2c_req_i), .i2c_we_i(i2c_we_i), .high_bank_select_i(high_bank_select_i),
   .i2c_pwd_ok_i(i2c_pwd_ok_i), .i2c_ack_o(i2c_ack_o), .i2c_denied_o(i2c_denied_o));

// File: dv/rf_host_model.sv
`timescale 1ns/100ps
module rf_host_model (
   input  wire logic   mclk_i,
   input  wire logic   rf_ready_i,
   input  wire logic   rf_done_i,
   output logic        rf_req_o,
   output logic [2:0]  rf_cmd_o,
   output logic [3:0]  rf_sector_o,
   output logic        rf_opt_o,
   output logic [1:0]  rf_pwd_sel_o,
   output logic [31:0] rf_data_o,
   output logic        i2c_req_o,
   output logic        i2c_we_o,
   output logic        high_bank_select_o,
   output logic [3:0]  i2c_addr_o,
   output logic [7:0]  i2c_wdata_o,
   output logic        i2c_pwd_ok_o,
   output logic        hung_o
);
   int n;
   initial begin
      {rf_req_o, rf_cmd_o, rf_sector_o, rf_opt_o, rf_pwd_sel_o, rf_data_o} = '0;
      {i2c_req_o, i2c_we_o, high_bank_select_o, i2c_addr_o, i2c_wdata_o} = '0;
      {i2c_pwd_ok_o, hung_o} = 2'h0;
   end
   task automatic rf_op(input logic [2:0] c, input logic [3:0] s, input logic o,
                        input logic [1:0] p, input logic [31:0] d, output int cyc);
      @(posedge mclk_i);
      #1;
      {rf_req_o, rf_cmd_o, rf_sector_o, rf_opt_o, rf_pwd_sel_o, rf_data_o} = {1'b1, c, s, o, p, d};
      n = 0;
      while (rf_ready_i !== 1'b1 && n < 50) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      @(posedge mclk_i);
      #1;
      rf_req_o = 1'b0;
      // released data and sector lines flip so a stale value never looks live
      rf_data_o = ~rf_data_o;
      rf_sector_o = ~rf_sector_o;
      cyc = 1;
      while (rf_done_i !== 1'b1 && cyc < 50) begin
         @(posedge mclk_i);
         #1;
         cyc++;
      end
      if (n >= 50 || cyc >= 50) hung_o = 1'b1;
   endtask
   task automatic i2c_op(input logic hb, input logic we, input logic [3:0] a,
                         input logic [7:0] d, input logic pok);
      @(posedge mclk_i);
      #1;
      {i2c_req_o, high_bank_select_o, i2c_we_o} = {1'b1, hb, we};
      {i2c_addr_o, i2c_wdata_o, i2c_pwd_ok_o} = {a, d, pok};
      @(posedge mclk_i);
      #1;
      i2c_req_o = 1'b0;
      i2c_addr_o = ~i2c_addr_o;
      i2c_wdata_o = ~i2c_wdata_o;
   endtask
endmodule

// File: dv/rf_sector_password_guard_tb_top.sv
`timescale 1ns/100ps
module rf_sector_password_guard_tb_top;
   localparam int         WC = 8;
   localparam logic [1:0] OK = guard_pkg::RESP_OK;
   localparam logic [1:0] DN = guard_pkg::RESP_DENIED;
   localparam logic [2:0] RD = guard_pkg::CMD_READ;
   localparam logic [2:0] PR = guard_pkg::CMD_PRESENT;
   localparam logic [2:0] WP = guard_pkg::CMD_WRITE_PWD;
   logic        mclk, resetn, rf_req, rf_ready, rf_opt, rf_done, rf_gv, i2c_req, i2c_we;
   logic        hbs, i2c_pok, i2c_ack, i2c_den, hung;
   logic [1:0]  rf_psel, rf_stat, rf_pres;
   logic [2:0]  rf_cmd;
   logic [3:0]  rf_sec, i2c_addr;
   logic [7:0]  rf_gb, i2c_wd, i2c_rd;
   logic [31:0] rf_data;
   int          num_errors, checks, cyc;
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   rf_sector_password_guard #(.WRITE_CYCLES(WC)) rf_sector_password_guard_i (
      .mclk_i(mclk), .resetn_i(resetn), .rf_req_i(rf_req), .rf_ready_o(rf_ready),
      .rf_cmd_i(rf_cmd), .rf_sector_i(rf_sec), .rf_opt_i(rf_opt), .rf_pwd_sel_i(rf_psel),
      .rf_data_i(rf_data), .rf_done_o(rf_done), .rf_status_o(rf_stat),
      .rf_guard_byte_o(rf_gb), .rf_guard_valid_o(rf_gv), .rf_presented_o(rf_pres),
      .i2c_req_i(i2c_req), .i2c_we_i(i2c_we), .high_bank_select_i(hbs), .i2c_addr_i(i2c_addr),
      .i2c_wdata_i(i2c_wd), .i2c_pwd_ok_i(i2c_pok), .i2c_ack_o(i2c_ack),
      .i2c_denied_o(i2c_den), .i2c_rdata_o(i2c_rd));
   rf_host_model rf_host_model_i (
      .mclk_i(mclk), .rf_ready_i(rf_ready), .rf_done_i(rf_done), .rf_req_o(rf_req),
      .rf_cmd_o(rf_cmd), .rf_sector_o(rf_sec), .rf_opt_o(rf_opt), .rf_pwd_sel_o(rf_psel),
      .rf_data_o(rf_data), .i2c_req_o(i2c_req), .i2c_we_o(i2c_we), .high_bank_select_o(hbs),
      .i2c_addr_o(i2c_addr), .i2c_wdata_o(i2c_wd), .i2c_pwd_ok_o(i2c_pok), .hung_o(hung));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rf(input logic [2:0] c, input logic [3:0] s, input logic o,
                     input logic [1:0] p, input logic [31:0] d);
      rf_host_model_i.rf_op(c, s, o, p, d, cyc);
      if (hung === 1'b1) begin
         num_errors++;
         close_out();
      end
   endtask
   task automatic i2c(input logic we, input logic [3:0] a, input logic [7:0] d, input logic k);
      rf_host_model_i.i2c_op(1'b1, we, a, d, k);
      chk("i2c ack", 1'b1, i2c_ack);
   endtask
   task automatic pr(input logic [1:0] p, input logic [31:0] d, input logic [1:0] st,
                     input logic [1:0] pres);
      rf(PR, 4'h0, 1'b0, p, d);
      chk("present status", st, rf_stat);
      chk("presented", pres, rf_pres);
   endtask
   // sectors 0..3 locked to password one with codes 0..3, sector 4 open
   function automatic logic [7:0] gb(input int s);
      gb = (s < 4) ? {3'h0, 2'h1, s[1:0], 1'b1} : 8'h0E;
   endfunction
   task automatic rights(input logic pw);
      logic [7:0] b;
      for (int s = 0; s < 5; s++) begin
         b = gb(s);
         rf(RD, s[3:0], 1'b0, 2'h0, 32'h0);
         chk("read right", (pw || !(b[0] && b[2])) ? OK : DN, rf_stat);
         rf(guard_pkg::CMD_WRITE, s[3:0], 1'b0, 2'h0, 32'h0);
         chk("write right",
             (b[0] && (pw ? b[2:1] == 2'h3 : b[2:1] != 2'h1)) ? DN : OK, rf_stat);
      end
   endtask
   task automatic s_reset();
      chk("presented", 2'h0, rf_pres);
      chk("rf ready", 1'b1, rf_ready);
      for (int s = 0; s < 16; s++) begin
         rf(RD, s[3:0], 1'b1, 2'h0, 32'h0);
         chk("rf guard", guard_pkg::GUARD_RESET, rf_gb);
         chk("guard valid", 1'b1, rf_gv);
         i2c(1'b0, s[3:0], 8'h00, 1'b0);
         chk("i2c guard", guard_pkg::GUARD_RESET, i2c_rd);
      end
      rf(RD, 4'h0, 1'b0, 2'h0, 32'h0);
      chk("guard valid", 1'b0, rf_gv);
   endtask
   task automatic s_lock();
      rf(guard_pkg::CMD_LOCK, 4'h9, 1'b0, 2'h0, 32'h0000_00EA);
      chk("lock status", OK, rf_stat);
      i2c(1'b0, 4'h9, 8'h00, 1'b0);
      chk("locked byte", 8'h0B, i2c_rd);
      rf(guard_pkg::CMD_LOCK, 4'h9, 1'b0, 2'h0, 32'h0000_00FF);
      chk("relock status", guard_pkg::RESP_LOCKED, rf_stat);
      rf(RD, 4'h9, 1'b1, 2'h0, 32'h0);
      chk("relock byte", 8'h0B, rf_gb);
   endtask
   task automatic s_rights();
      for (int s = 0; s < 5; s++) i2c(1'b1, s[3:0], gb(s), 1'b1);
      rights(1'b0);
      pr(2'h1, 32'h0, OK, 2'h1);
      rights(1'b1);
      pr(2'h2, 32'h0, OK, 2'h2);
      rights(1'b0);
      pr(2'h1, 32'h0, OK, 2'h1);
   endtask
   task automatic s_i2c();
      i2c(1'b1, 4'h2, gb(2), 1'b1);
      rf(RD, 4'h2, 1'b0, 2'h0, 32'h0);
      chk("voided read", DN, rf_stat);
      rf(RD, 4'h3, 1'b0, 2'h0, 32'h0);
      chk("kept read", OK, rf_stat);
      i2c(1'b1, 4'h2, 8'h00, 1'b0);
      chk("i2c denied", 1'b1, i2c_den);
      rf_host_model_i.i2c_op(1'b0, 1'b1, 4'h2, 8'h00, 1'b1);
      chk("no bank ack", 1'b0, i2c_ack);
      i2c(1'b0, 4'h2, 8'h00, 1'b0);
      chk("guard kept", gb(2), i2c_rd);
   endtask
   task automatic s_pwd();
      pr(2'h3, 32'h0, OK, 2'h3);
      rf(WP, 4'h0, 1'b0, 2'h1, 32'hA5C3_0F1E);
      chk("write unpresented", DN, rf_stat);
      chk("deny time", 1, cyc);
      pr(2'h1, 32'h0, OK, 2'h1);
      rf(WP, 4'h0, 1'b0, 2'h1, 32'hA5C3_0F1E);
      chk("write pwd", OK, rf_stat);
      chk("write time", WC + 1, cyc);
      pr(2'h1, 32'h0, DN, 2'h0);
      rf(RD, 4'h3, 1'b0, 2'h0, 32'h0);
      chk("withdrawn", DN, rf_stat);
      pr(2'h1, 32'hA5C3_0F1E, OK, 2'h1);
      resetn = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      resetn = 1'b1;
      chk("presented after reset", 2'h0, rf_pres);
      pr(2'h0, 32'h0, guard_pkg::RESP_BAD, 2'h0);
   endtask
   initial begin
      num_errors = 0;
      checks = 0;
      resetn = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      resetn = 1'b1;
      s_reset();
      s_lock();
      s_rights();
      s_i2c();
      s_pwd();
      close_out();
   end
endmodule
